//--- acquisition_period_power_scheduler_tb.sv
// self-checking bench for the acquisition scheduler
`timescale 1ns/1ps
`default_nettype none
`include "apsc_map.vh"
module acquisition_period_power_scheduler_tb;
  logic        pclk = 1'b0;    // 10 MHz clock
  logic        presetn = 1'b0; // reset, active low
  logic        psel = 1'b0;    // bus request
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;             // last read data
  logic        err;            // last error flag
  wire         pready, pslverr, log_tick, calc_tick, mvt_s, prb_s, xpwr;
  wire  [31:0] prdata;
  wire  [3:0]  asmp, apwr;
  wire  [2:0]  psmp, ppwr;
  int          miscompares = 0;
  int          tests_run = 0;
  // short tick keeps long periods affordable
  apsc_scheduler #(.TICK_CYC(10)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .log_tick(log_tick),
    .calc_tick(calc_tick), .analog_sample(asmp),
    .multivariable_transducer_sample(mvt_s),
    .temperature_probe_sample(prb_s), .pulse_sample(psmp),
    .xducer_power(xpwr), .analog_xmtr_power(apwr),
    .pulse_xmtr_power(ppwr));
  initial forever #50 pclk = ~pclk;
  // hang guard
  initial
  begin
    #10000000;
    miscompares++;
    wrap_up;
  end
  task automatic wrap_up;
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one bus transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      cmp(32'h0, 32'h1);
      wrap_up;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // counts settle slowly, so reread until they match or give up
  task automatic poll(input logic [11:0] a, input logic [31:0] e);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd !== e && n < 15000);
    cmp(rd, e);
    if (rd !== e)
      wrap_up;
  endtask
  function automatic logic ev(input int s);
    case (s)
      0: return calc_tick;
      1: return log_tick;
      2: return asmp[0];
      3: return psmp[2];
      5: return prb_s;
      default: return !xpwr;
    endcase
  endfunction
  // sampled on the falling edge, where registered outputs are settled
  task automatic wait_ev(input int s, output int c);
    c = 0;
    do
    begin
      @(negedge pclk);
      c++;
    end while (ev(s) !== 1'b1 && c < 20000);
    if (c >= 20000)
    begin
      miscompares++;
      wrap_up;
    end
  endtask
  task automatic period(input int s, input int e);
    int c;
    wait_ev(s, c);
    wait_ev(s, c);
    cmp(c, e);
  endtask
  task automatic count(input int s, output int n);
    n = 0;
    repeat (400)
    begin
      @(negedge pclk);
      if (ev(s) === 1'b1)
        n++;
    end
  endtask
  // defaults, then a short logging period before its first fire
  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, `APSC_LOG_RST);
    apb(1'b1, 12'h000, 32'd100);
    apb(1'b0, 12'h004, 32'h0);
    cmp(rd, `APSC_CALC_RST);
    apb(1'b0, 12'h008, 32'h0);
    cmp(rd, `APSC_SAMP_RST);
    apb(1'b0, 12'h010, 32'h0);
    cmp(rd, `APSC_IN_EN_RST);
  endtask
  task automatic t_rates;
    apb(1'b1, 12'h004, 32'd20);
    apb(1'b1, 12'h008, 32'd4);
    apb(1'b1, 12'h010, 32'h13f);
    period(0, 200);
    period(1, 1000);
    period(2, 40);
    period(3, 100);
    poll(12'h02c, 32'd5);
    poll(12'h030, 32'd5);
  endtask
  task automatic t_warm;
    int n;
    apb(1'b1, 12'h00c, 32'h8000_0002);
    count(4, n);
    cmp(n != 0, 1);
    apb(1'b1, 12'h00c, 32'h8000_ffff);
    apb(1'b0, 12'h00c, 32'h0);
    cmp(rd, 32'h8000_1770);
    period(2, 40);
    count(4, n);
    cmp(n, 0);
    apb(1'b1, 12'h00c, 32'h0000_0002);
  endtask
  task automatic t_invalid;
    int n;
    apb(1'b1, 12'h008, 32'd30);
    poll(12'h028, 32'h1);
    apb(1'b1, 12'h008, 32'd4);
    poll(12'h028, 32'h0);
    apb(1'b1, 12'h010, 32'h130);
    // a sample launched by the write edge may still stand here
    @(negedge pclk);
    count(2, n);
    cmp(n, 0);
    period(5, 40);
  endtask
  task automatic t_power;
    apb(1'b1, 12'h014, 32'h0000_7011);
    @(negedge pclk);
    @(negedge pclk);
    cmp({apwr, ppwr}, 7'h0f);
    apb(1'b1, 12'h014, 32'h0000_7010);
    apb(1'b0, 12'h014, 32'h0);
    cmp(rd, 32'h0);
    cmp({apwr, ppwr}, 7'h00);
  endtask
  // unmapped and read-only places
  task automatic t_err;
    apb(1'b0, 12'h034, 32'h0);
    cmp(err, 1'b1);
    cmp(rd, 32'h0);
    apb(1'b1, 12'h02c, 32'h0);
    apb(1'b0, 12'h02c, 32'h0);
    cmp(rd, 32'd5);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_rates;
    t_warm;
    t_invalid;
    t_power;
    t_err;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    wrap_up;
  end
endmodule // acquisition_period_power_scheduler_tb
`default_nettype wire

//--- apsc_map.vh
// register map, reset values and timing constants of the acquisition scheduler
// Operation
// R1: logging tick every 1 s to 12 h, default 1 h
// R2: calculation tick every 1 s to 12 h, default 1 min
// R3: report calculations per logging interval
// R4: flag sampling period longer than calculation period
// R5: sampling every 0.1 s to 12 h, default 1 s
// R6: report samples per calculation period
// R7: pulse inputs at 1 s; pulse 3 off at reset
// R8: disabled input gives no samples
// R9: warm-up power at least warm-up time before sample
// R10: long period: power off between samples
// R11: warm-up longer than period: power stays on
// R12: excitation always-on or warm-up, 0.1 s to 10 min
// R13: three pulse and four analog supply outputs
// R14: global disable switches every transmitter supply off
// R15: analog supply follows off, on or warm-up setting
// R16: pulse supply only off or on
// R17: all periods counted in 0.1 s ticks, reset clears
`ifndef APSC_MAP_VH
`define APSC_MAP_VH
// byte offsets
`define APSC_LOG_PER     12'h000
`define APSC_CALC_PER    12'h004
`define APSC_SAMP_PER    12'h008
`define APSC_WARM        12'h00c
`define APSC_IN_EN       12'h010
`define APSC_XMTR        12'h014
`define APSC_XWARM0      12'h018
`define APSC_STATUS      12'h028
`define APSC_CALC_CNT    12'h02c
`define APSC_SAMP_CNT    12'h030
// periods in 0.1 s ticks, tick and clock lengths in ns
`define APSC_LOG_RST     20'd36000
`define APSC_CALC_RST    20'd600
`define APSC_SAMP_RST    20'd10
`define APSC_PULSE_PER   20'd10
`define APSC_PER_MIN     20'd1
`define APSC_SEC_MIN     20'd10
`define APSC_PER_MAX     20'd432000
`define APSC_WARM_MIN    20'd1
`define APSC_WARM_MAX    20'd6000
`define APSC_TICK_NS     100000000
`define APSC_CLK_NS      100
// input enable reset: analog 3:0 off, mvt 4, probe 5, pulse 8..6 = 0,1,1
`define APSC_IN_EN_RST   9'h0c0
`endif

//--- apsc_monitor.sv
// port checker for the acquisition scheduler, bound to its top
`timescale 1ns/1ps
`default_nettype none
module apsc_monitor #(
  parameter TICK_CYC = 10
) (
  // bus side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // acquisition side
  input wire logic        calc_tick,
  input wire logic [3:0]  analog_sample,
  input wire logic        multivariable_transducer_sample,
  input wire logic [2:0]  pulse_sample,
  input wire logic        xducer_power,
  input wire logic [3:0]  analog_xmtr_power,
  input wire logic [2:0]  pulse_xmtr_power
);
  localparam int PER = 10 * TICK_CYC; // clocks per pulse sample
  wire         wr = psel & penable & pwrite; // write taken
  logic [31:0] gap_q;  // clocks since last pulse sample
  logic        seen_q; // first pulse sample passed
  logic        glob_q; // global supply mode shadow
  logic        warm_q; // warm-up excitation shadow
  logic [5:0]  en_q;   // enables of pulse 3, mvt, analog
  wire  [5:0]  smp = {pulse_sample[2], multivariable_transducer_sample,
                      analog_sample};
  // shadows track bus writes, so the checks need no hierarchy
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
      glob_q <= 1'b0;
      warm_q <= 1'b0;
      en_q   <= 6'h00;
    end
    else
    begin
      gap_q <= pulse_sample[0] ? 32'h1 : gap_q + 32'h1;
      if (pulse_sample[0])
        seen_q <= 1'b1;
      if (wr && paddr == 12'h010)
        en_q <= {pwdata[8], pwdata[4:0]};
      if (wr && paddr == 12'h014)
        glob_q <= pwdata[0];
      if (wr && paddr == 12'h00c)
        warm_q <= pwdata[31];
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pulse_gap: assert property (
    pulse_sample[0] && seen_q |-> gap_q == PER)
    else $error("pulse spacing wrong");
  chk_pulse_max: assert property (gap_q <= PER)
    else $error("pulse sample missing");
  chk_pulse_pair: assert property (
    pulse_sample[0] == pulse_sample[1])
    else $error("pulse one and two differ");
  chk_supply_off: assert property (
    !glob_q && !$past(glob_q) |->
    {analog_xmtr_power, pulse_xmtr_power} == 7'h00)
    else $error("supply on while disabled");
  chk_input_gate: assert property (
    (smp & ~en_q & ~$past(en_q)) == 6'h00)
    else $error("sample from disabled input");
  chk_excite_on: assert property (
    !warm_q && !$past(warm_q) |-> xducer_power)
    else $error("always-on excitation dropped");
  chk_warm_lead: assert property (
    multivariable_transducer_sample |->
    xducer_power && $past(xducer_power, 8))
    else $error("sample without warm-up");
  chk_calc_once: assert property (
    calc_tick |=> (!calc_tick) [*8])
    else $error("calculation tick too long");
endmodule // apsc_monitor
bind apsc_scheduler apsc_monitor #(.TICK_CYC(TICK_CYC)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .calc_tick(calc_tick), .analog_sample(analog_sample),
  .multivariable_transducer_sample(multivariable_transducer_sample),
  .pulse_sample(pulse_sample), .xducer_power(xducer_power),
  .analog_xmtr_power(analog_xmtr_power),
  .pulse_xmtr_power(pulse_xmtr_power));
`default_nettype wire

//--- apsc_scheduler.v
// acquisition period and excitation power scheduler with an apb slave
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "apsc_map.vh"
module apsc_scheduler #(
  parameter TICK_CYC = `APSC_TICK_NS / `APSC_CLK_NS  // clocks per 0.1 s
) (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // acquisition ticks, one cycle each
  output reg         log_tick,
  output reg         calc_tick,
  output reg  [3:0]  analog_sample,
  output reg         multivariable_transducer_sample,
  output reg         temperature_probe_sample,
  output reg  [2:0]  pulse_sample,
  // power outputs
  output reg         xducer_power,
  output reg  [3:0]  analog_xmtr_power,
  output reg  [2:0]  pulse_xmtr_power
);

  // excitation and supply codes
  localparam [1:0] PW_OFF = 2'd0;
  localparam [1:0] PW_ON  = 2'd1;
  localparam [1:0] PW_WARM = 2'd2;

  // clamp a written period into its legal range
  function [19:0] clamp;
    input [31:0] v;
    input [19:0] lo;
    input [19:0] hi;
    begin
      if (v < {12'h000, lo})
        clamp = lo;
      else if (v > {12'h000, hi})
        clamp = hi;
      else
        clamp = v[19:0];
    end
  endfunction

  // warm-up decision: power on when remaining time is within warm-up
  function pw_need;
    input [1:0]  mode;
    input [19:0] warm;
    input [19:0] per;
    input [19:0] left;
    begin
      if (mode == PW_ON)
        pw_need = 1'b1;
      else if (mode == PW_WARM)
        pw_need = (warm >= per) || (left <= warm);      // R9 R10 R11
      else
        pw_need = 1'b0;
    end
  endfunction

  // configuration registers
  reg [19:0] log_per_q;                  // logging period, ticks
  reg [19:0] calc_per_q;                 // calculation period, ticks
  reg [19:0] samp_per_q;                 // sampling period, ticks
  reg [19:0] warm_q;                     // integrated warm-up time
  reg        xdc_mode_q;                 // 1 = warm-up, 0 = always on
  reg [8:0]  in_en_q;                    // per-input sample enables
  reg        xmtr_glb_q;                 // 1 = enabled if required
  reg [7:0]  a_mode_q;                   // analog supply modes, 2 bits each
  reg [2:0]  p_mode_q;                   // pulse supply on bits
  reg [19:0] xwarm_q [0:3];              // analog warm-up times
  // counters
  reg [23:0] pre_q;                      // clocks inside one 0.1 s tick
  reg        tick_q;                     // 0.1 s strobe
  reg [19:0] log_cnt_q;
  reg [19:0] calc_cnt_q;
  reg [19:0] samp_cnt_q;
  reg [19:0] pulse_cnt_q;
  // derived ratios, recomputed by a slow subtractive divider
  reg [19:0] calc_per_log_q;
  reg [19:0] samp_per_calc_q;
  reg [19:0] div_rem_q;
  reg [19:0] div_quo_q;
  reg        div_sel_q;                  // 0 = calc/log, 1 = samp/calc
  integer    i;                          // loop index of the write process
  integer    j;                          // loop index of the power process

  wire wr = psel & penable & pwrite;
  wire rd = psel & ~penable & ~pwrite;
  wire cfg_bad = samp_per_q > calc_per_q;                       // R4
  wire mapped = (paddr[11:6] == 6'd0) && (paddr[1:0] == 2'b00) &&
                (paddr[5:2] <= 4'hc);

  // zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // 0.1 s prescaler
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q  <= 24'h000000;
      tick_q <= 1'b0;
    end
    else if (pre_q == TICK_CYC[23:0] - 24'h000001)
    begin
      pre_q  <= 24'h000000;
      tick_q <= 1'b1;                                           // R17
    end
    else
    begin
      pre_q  <= pre_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

  // register writes, periods clamped to legal ranges
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      log_per_q  <= `APSC_LOG_RST;                              // R1
      calc_per_q <= `APSC_CALC_RST;                             // R2
      samp_per_q <= `APSC_SAMP_RST;                             // R5
      warm_q     <= `APSC_WARM_MIN;
      xdc_mode_q <= 1'b0;
      in_en_q    <= `APSC_IN_EN_RST;                            // R7
      xmtr_glb_q <= 1'b0;
      a_mode_q   <= 8'h00;
      p_mode_q   <= 3'h0;
      for (i = 0; i < 4; i = i + 1)
        xwarm_q[i] <= `APSC_WARM_MIN;
    end
    else if (wr && mapped)
    begin
      case (paddr[5:2])
        4'h0: log_per_q  <= clamp(pwdata, `APSC_SEC_MIN, `APSC_PER_MAX);
        4'h1: calc_per_q <= clamp(pwdata, `APSC_SEC_MIN, `APSC_PER_MAX);
        4'h2: samp_per_q <= clamp(pwdata, `APSC_PER_MIN, `APSC_PER_MAX);
        4'h3:
        begin
          warm_q     <= clamp({12'h000, pwdata[19:0]},
                              `APSC_WARM_MIN, `APSC_WARM_MAX);  // R12
          xdc_mode_q <= pwdata[31];
        end
        // pulse inputs 1 and 2 can never be cleared
        4'h4: in_en_q <= {pwdata[8], 2'b11, pwdata[5:0]};       // R7
        4'h5:
        begin
          xmtr_glb_q <= pwdata[0];
          a_mode_q   <= pwdata[11:4];
          p_mode_q   <= pwdata[14:12];                          // R16
        end
        4'h6, 4'h7, 4'h8, 4'h9:
          xwarm_q[paddr[3:2] - 2'd2] <=
            clamp({12'h000, pwdata[19:0]},
                  `APSC_WARM_MIN, `APSC_WARM_MAX);              // R15
        default: ;
      endcase
    end
    else if (!xmtr_glb_q)
    begin
      // global disable forces all per-input supply modes off
      a_mode_q <= 8'h00;                                        // R14
      p_mode_q <= 3'h0;                                         // R14
    end
  end

  // period counters count down in 0.1 s ticks, fire at zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      log_cnt_q   <= 20'd0;                                     // R17
      calc_cnt_q  <= 20'd0;
      samp_cnt_q  <= 20'd0;
      pulse_cnt_q <= 20'd0;
      log_tick    <= 1'b0;
      calc_tick   <= 1'b0;
      analog_sample <= 4'h0;
      multivariable_transducer_sample <= 1'b0;
      temperature_probe_sample <= 1'b0;
      pulse_sample <= 3'h0;
    end
    else
    begin
      log_tick      <= 1'b0;
      calc_tick     <= 1'b0;
      analog_sample <= 4'h0;
      multivariable_transducer_sample <= 1'b0;
      temperature_probe_sample <= 1'b0;
      pulse_sample  <= 3'h0;
      if (tick_q)
      begin
        // counters hold remaining ticks; period-1 after a fire
        if (log_cnt_q == 20'd0)
        begin
          log_cnt_q <= log_per_q - 20'd1;
          log_tick  <= 1'b1;                                    // R1
        end
        else
          log_cnt_q <= log_cnt_q - 20'd1;
        if (calc_cnt_q == 20'd0)
        begin
          calc_cnt_q <= calc_per_q - 20'd1;
          calc_tick  <= 1'b1;                                   // R2
        end
        else
          calc_cnt_q <= calc_cnt_q - 20'd1;
        if (samp_cnt_q == 20'd0)
        begin
          samp_cnt_q    <= samp_per_q - 20'd1;
          analog_sample <= in_en_q[3:0];                        // R8
          multivariable_transducer_sample <= in_en_q[4];        // R8
          temperature_probe_sample <= in_en_q[5];               // R8
        end
        else
          samp_cnt_q <= samp_cnt_q - 20'd1;
        if (pulse_cnt_q == 20'd0)
        begin
          pulse_cnt_q  <= `APSC_PULSE_PER - 20'd1;
          pulse_sample <= in_en_q[8:6];                         // R7 R8
        end
        else
          pulse_cnt_q <= pulse_cnt_q - 20'd1;
      end
    end
  end

  // ratio divider: repeated subtraction, alternates both ratios
  // slow but small; a fresh result lands within a period's ticks
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_rem_q       <= 20'd0;
      div_quo_q       <= 20'd0;
      div_sel_q       <= 1'b0;
      calc_per_log_q  <= 20'd0;
      samp_per_calc_q <= 20'd0;
    end
    else if (div_rem_q >= (div_sel_q ? samp_per_q : calc_per_q))
    begin
      div_rem_q <= div_rem_q - (div_sel_q ? samp_per_q : calc_per_q);
      div_quo_q <= div_quo_q + 20'd1;
    end
    else
    begin
      if (div_sel_q)
        samp_per_calc_q <= div_quo_q;                           // R6
      else
        calc_per_log_q  <= div_quo_q;                           // R3
      div_sel_q <= ~div_sel_q;
      div_rem_q <= div_sel_q ? log_per_q : calc_per_q;
      div_quo_q <= 20'd0;
    end
  end

  // power outputs, ahead of the next sample by the warm-up time
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xducer_power      <= 1'b1;
      analog_xmtr_power <= 4'h0;
      pulse_xmtr_power  <= 3'h0;
    end
    else
    begin
      xducer_power <= pw_need(xdc_mode_q ? PW_WARM : PW_ON,
                              warm_q, samp_per_q, samp_cnt_q);  // R12
      // own index, so no variable is driven from two processes
      for (j = 0; j < 4; j = j + 1)
        analog_xmtr_power[j] <= xmtr_glb_q &
          pw_need(a_mode_q[2*j +: 2], xwarm_q[j],
                  samp_per_q, samp_cnt_q);                      // R13 R15
      pulse_xmtr_power <= xmtr_glb_q ? p_mode_q : 3'h0;         // R13 R14
    end
  end

  // read mux, registered on the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd)
    begin
      case (paddr[5:2])
        4'h0: prdata <= {12'h000, log_per_q};
        4'h1: prdata <= {12'h000, calc_per_q};
        4'h2: prdata <= {12'h000, samp_per_q};
        4'h3: prdata <= {xdc_mode_q, 11'h000, warm_q};
        4'h4: prdata <= {23'h000000, in_en_q};
        4'h5: prdata <= {17'h00000, p_mode_q, a_mode_q, 3'h0, xmtr_glb_q};
        4'h6, 4'h7, 4'h8, 4'h9:
          prdata <= {12'h000, xwarm_q[paddr[3:2] - 2'd2]};
        4'ha: prdata <= {31'h00000000, cfg_bad};                 // R4
        4'hb: prdata <= {12'h000, calc_per_log_q};
        4'hc: prdata <= {12'h000, samp_per_calc_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // apsc_scheduler
`default_nettype wire
